/* hims_dev.sv */
// touch device end: strap latch, i2c / spi / lin slave and interrupt pin
`timescale 1ns/1ps
// What this block does
// - i2c slave works up to 400 kHz
// - spi slave uses four pins, up to 4 MHz
// - lin uart slave up to 20 kBaud
// - lin mode drives transceiver enable on interrupt pin
// - straps sampled once at start-up, mode fixed
// - board pulls bus strap low or high
// - spi mode turns bus strap into data out
// - address strap picks 0x66 or 0x67
// - host holds select low across transaction
// - select tied low still works
// - both ends use spi mode 0
// - pending reports shown on interrupt pin in i2c and spi modes
// - clock idles low, sample rising, shift falling
module hims_dev import hims_pkg::*; #(
   parameter int unsigned LIN_BIT_CYC = LIN_BIT
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // link pins
   hims_if.dev             lnk,
   // user side requests
   input  wire logic       rpt_evt,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_go,
   input  wire logic       lin_en,
   // user side answers
   output logic [7:0]      rx_data_q,
   output logic            rx_valid_q,
   output logic            tx_take_q,
   output hims_mode_t      mode_q,
   output logic [6:0]      i2c_addr_q,
   output logic            rpt_pend_q
);
   // ----------------------------------------------------------------
   // pin synchronisers and strap latch
   // ----------------------------------------------------------------
   logic [3:0] s1_q, s2_q, s3_q, f_q, pf_q, f_d;
   logic [3:0] wait_q, wait_d;
   hims_mode_t mode_d;
   logic [6:0] addr_d;
   logic       scl_r, scl_fe, i2c_start, i2c_stop;

   // a bit changes only once the second and third stage agree
   assign f_d = (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
   assign scl_r     = f_q[PIN_P1] & ~pf_q[PIN_P1];
   assign scl_fe    = ~f_q[PIN_P1] & pf_q[PIN_P1];
   assign i2c_start = f_q[PIN_P1] & pf_q[PIN_P1] & pf_q[PIN_P0] & ~f_q[PIN_P0];
   assign i2c_stop  = f_q[PIN_P1] & pf_q[PIN_P1] & ~pf_q[PIN_P0] & f_q[PIN_P0];

   // straps settle through the synchroniser before they are caught
   always_comb begin
      wait_d = wait_q;
      mode_d = mode_q;
      addr_d = i2c_addr_q;
      if (mode_q == HIMS_NONE) begin
         if (wait_q == STRAP_WAIT) begin
            addr_d = f_q[PIN_ADDR] ? I2C_ADDR_HI : I2C_ADDR_LO;
            if (!f_q[PIN_BUS])
               mode_d = HIMS_I2C;
            else if (f_q[PIN_ADDR])
               mode_d = HIMS_SPI;
            else
               mode_d = HIMS_LIN;
         end else begin
            wait_d = wait_q + 4'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s1_q       <= 4'hf;
         s2_q       <= 4'hf;
         s3_q       <= 4'hf;
         f_q        <= 4'hf;
         pf_q       <= 4'hf;
         wait_q     <= 4'h0;
         mode_q     <= HIMS_NONE;
         i2c_addr_q <= I2C_ADDR_LO;
      end else begin
         s1_q       <= {lnk.bus, lnk.addr, lnk.p1, lnk.p0};
         s2_q       <= s1_q;
         s3_q       <= s2_q;
         f_q        <= f_d;
         pf_q       <= f_q;
         wait_q     <= wait_d;
         mode_q     <= mode_d;   // held until the next reset
         i2c_addr_q <= addr_d;
      end
   end

   // ----------------------------------------------------------------
   // i2c slave
   // ----------------------------------------------------------------
   hims_i2c_st_t ist_q, ist_d;
   logic [3:0]   icnt_q, icnt_d;
   logic [7:0]   ish_q, ish_d;
   logic         irw_q, irw_d, irel_q, irel_d;
   logic         i_wr_v, i_take, i_rd_done;

   // byte-level slave; timing is set by the host clock, so any rate the
   // synchroniser can follow (well past 400 kHz) is served
   always_comb begin
      ist_d     = ist_q;
      icnt_d    = icnt_q;
      ish_d     = ish_q;
      irw_d     = irw_q;
      irel_d    = irel_q;
      i_wr_v    = 1'b0;
      i_take    = 1'b0;
      i_rd_done = 1'b0;
      if (mode_q != HIMS_I2C) begin
         ist_d  = I_IDLE;
         irel_d = 1'b1;
      end else if (i2c_start) begin
         ist_d  = I_ADDR;
         icnt_d = 4'h0;
         irel_d = 1'b1;
      end else if (i2c_stop) begin
         ist_d  = I_IDLE;
         irel_d = 1'b1;
      end else begin
         case (ist_q)
            I_ADDR, I_WR: begin
               if (scl_r) begin
                  ish_d  = {ish_q[6:0], f_q[PIN_P0]};
                  icnt_d = icnt_q + 4'h1;
               end
               if (scl_fe && icnt_q == 4'h8) begin
                  if (ist_q == I_WR) begin
                     i_wr_v = 1'b1;
                     irel_d = 1'b0;
                     ist_d  = I_ACK;
                  end else if (ish_q[7:1] == i2c_addr_q) begin
                     irw_d  = ish_q[0];
                     irel_d = 1'b0;
                     ist_d  = I_ACK;
                  end else begin
                     ist_d = I_IDLE;   // other slave addressed
                  end
               end
            end
            I_ACK: begin
               if (scl_fe) begin
                  icnt_d = 4'h0;
                  if (irw_q) begin
                     ish_d  = tx_data;
                     i_take = 1'b1;
                     irel_d = tx_data[7];
                     ist_d  = I_RD;
                  end else begin
                     irel_d = 1'b1;
                     ist_d  = I_WR;
                  end
               end
            end
            I_RD: begin
               if (scl_fe) begin
                  icnt_d = icnt_q + 4'h1;
                  if (icnt_q == 4'h7) begin
                     irel_d = 1'b1;
                     ist_d  = I_RACK;
                  end else begin
                     ish_d  = {ish_q[6:0], 1'b0};
                     irel_d = ish_q[6];
                  end
               end
            end
            I_RACK: begin
               if (scl_r) begin
                  i_rd_done = 1'b1;
                  ist_d     = f_q[PIN_P0] ? I_IDLE : I_ACK;
               end
            end
            default: ist_d = I_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ist_q  <= I_IDLE;
         icnt_q <= 4'h0;
         ish_q  <= 8'h00;
         irw_q  <= 1'b0;
         irel_q <= 1'b1;
      end else begin
         ist_q  <= ist_d;
         icnt_q <= icnt_d;
         ish_q  <= ish_d;
         irw_q  <= irw_d;
         irel_q <= irel_d;
      end
   end

   // ----------------------------------------------------------------
   // spi slave, mode 0
   // ----------------------------------------------------------------
   logic [2:0] scnt_q, scnt_d;
   logic [7:0] srx_q, srx_d, stx_q, stx_d;
   logic       s_v, s_take, s_sel;

   assign s_sel = (mode_q == HIMS_SPI) & ~f_q[PIN_P1];

   always_comb begin
      scnt_d = scnt_q;
      srx_d  = srx_q;
      stx_d  = stx_q;
      s_v    = 1'b0;
      s_take = 1'b0;
      if (!s_sel) begin
         scnt_d = 3'h0;
         stx_d  = tx_data;
      end else begin
         // first selected cycle: the byte already tracked in stx is committed
         s_take = pf_q[PIN_P1];
         if (f_q[PIN_P0] & ~pf_q[PIN_P0]) begin
            srx_d  = {srx_q[6:0], f_q[PIN_ADDR]};
            scnt_d = scnt_q + 3'h1;
            s_v    = (scnt_q == 3'h7);
         end
         if (~f_q[PIN_P0] & pf_q[PIN_P0]) begin
            // reload on byte boundary so a select tied low still frames bytes
            if (scnt_q == 3'h0) begin
               stx_d  = tx_data;
               s_take = 1'b1;
            end else begin
               stx_d = {stx_q[6:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         scnt_q <= 3'h0;
         srx_q  <= 8'h00;
         stx_q  <= 8'h00;
      end else begin
         scnt_q <= scnt_d;
         srx_q  <= srx_d;
         stx_q  <= stx_d;
      end
   end

   // ----------------------------------------------------------------
   // lin uart slave, 8n1
   // ----------------------------------------------------------------
   logic        urx_busy_q, urx_busy_d, utx_busy_q, utx_busy_d, u_v, u_take;
   logic [15:0] urx_cnt_q, urx_cnt_d, utx_cnt_q, utx_cnt_d;
   logic [3:0]  urx_bit_q, urx_bit_d, utx_bit_q, utx_bit_d;
   logic [7:0]  urx_sh_q, urx_sh_d;
   logic [9:0]  utx_sh_q, utx_sh_d;

   // receive samples mid-bit; a start that vanishes is dropped as a glitch
   always_comb begin
      urx_busy_d = urx_busy_q;
      urx_cnt_d  = urx_cnt_q;
      urx_bit_d  = urx_bit_q;
      urx_sh_d   = urx_sh_q;
      u_v        = 1'b0;
      if (mode_q != HIMS_LIN) begin
         urx_busy_d = 1'b0;
      end else if (!urx_busy_q) begin
         if (pf_q[PIN_P0] & ~f_q[PIN_P0]) begin
            urx_busy_d = 1'b1;
            urx_cnt_d  = 16'(LIN_BIT_CYC / 2);
            urx_bit_d  = 4'h0;
         end
      end else if (urx_cnt_q != 16'h0000) begin
         urx_cnt_d = urx_cnt_q - 16'h0001;
      end else begin
         urx_cnt_d = 16'(LIN_BIT_CYC - 1);
         urx_bit_d = urx_bit_q + 4'h1;
         if (urx_bit_q == 4'h0) begin
            urx_busy_d = ~f_q[PIN_P0];
         end else if (urx_bit_q == 4'h9) begin
            urx_busy_d = 1'b0;
            u_v        = f_q[PIN_P0];   // framing error drops the byte
         end else begin
            urx_sh_d = {f_q[PIN_P0], urx_sh_q[7:1]};
         end
      end
   end

   // transmit shifts ones in behind the frame so the line idles high
   always_comb begin
      utx_busy_d = utx_busy_q;
      utx_cnt_d  = utx_cnt_q;
      utx_bit_d  = utx_bit_q;
      utx_sh_d   = utx_sh_q;
      u_take     = 1'b0;
      if (!utx_busy_q) begin
         if (tx_go && mode_q == HIMS_LIN) begin
            utx_sh_d   = {1'b1, tx_data, 1'b0};
            utx_busy_d = 1'b1;
            utx_cnt_d  = 16'(LIN_BIT_CYC - 1);
            utx_bit_d  = 4'h0;
            u_take     = 1'b1;
         end
      end else if (utx_cnt_q != 16'h0000) begin
         utx_cnt_d = utx_cnt_q - 16'h0001;
      end else if (utx_bit_q == 4'h9) begin
         utx_busy_d = 1'b0;
      end else begin
         utx_sh_d  = {1'b1, utx_sh_q[9:1]};
         utx_bit_d = utx_bit_q + 4'h1;
         utx_cnt_d = 16'(LIN_BIT_CYC - 1);
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         urx_busy_q <= 1'b0;
         urx_cnt_q  <= 16'h0000;
         urx_bit_q  <= 4'h0;
         urx_sh_q   <= 8'h00;
         utx_busy_q <= 1'b0;
         utx_cnt_q  <= 16'h0000;
         utx_bit_q  <= 4'h0;
         utx_sh_q   <= 10'h3ff;
      end else begin
         urx_busy_q <= urx_busy_d;
         urx_cnt_q  <= urx_cnt_d;
         urx_bit_q  <= urx_bit_d;
         urx_sh_q   <= urx_sh_d;
         utx_busy_q <= utx_busy_d;
         utx_cnt_q  <= utx_cnt_d;
         utx_bit_q  <= utx_bit_d;
         utx_sh_q   <= utx_sh_d;
      end
   end

   // ----------------------------------------------------------------
   // report flag, pin drivers, user answers
   // ----------------------------------------------------------------
   logic pend_d, p1_oe_n_q, irq_o_q, irq_oe_n_q, bus_oe_n_q;

   // a new report in the clearing cycle keeps the flag set
   assign pend_d = rpt_evt | (rpt_pend_q & ~(i_rd_done | s_v));

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rpt_pend_q <= 1'b0;
         p1_oe_n_q  <= 1'b1;
         irq_o_q    <= 1'b0;
         irq_oe_n_q <= 1'b1;
         bus_oe_n_q <= 1'b1;
         rx_data_q  <= 8'h00;
         rx_valid_q <= 1'b0;
         tx_take_q  <= 1'b0;
      end else begin
         rpt_pend_q <= pend_d;
         p1_oe_n_q  <= (mode_d != HIMS_LIN);
         irq_o_q    <= (mode_d == HIMS_LIN) & lin_en;
         // low while pending in i2c and spi, else released to the pull-up; lin drives it always
         irq_oe_n_q <= (mode_d == HIMS_LIN) ? 1'b0 : ~(pend_d && mode_d != HIMS_NONE);
         bus_oe_n_q <= ~((mode_d == HIMS_SPI) & ~f_d[PIN_P1]);
         rx_valid_q <= i_wr_v | s_v | u_v;
         tx_take_q  <= i_take | s_take | u_take;
         if (i_wr_v)
            rx_data_q <= ish_q;
         else if (s_v)
            rx_data_q <= srx_d;
         else if (u_v)
            rx_data_q <= urx_sh_q;
      end
   end

   assign lnk.d_p0_o     = 1'b0;
   assign lnk.d_p0_oe_n  = irel_q;   // open drain data
   assign lnk.d_p1_o     = utx_sh_q[0];
   assign lnk.d_p1_oe_n  = p1_oe_n_q;
   assign lnk.d_irq_o    = irq_o_q;
   assign lnk.d_irq_oe_n = irq_oe_n_q;
   assign lnk.d_bus_o    = stx_q[7];
   assign lnk.d_bus_oe_n = bus_oe_n_q;
endmodule // hims_dev

/* hims_pkg.sv */
// shared constants and types for the host interface mode select block
package hims_pkg;
   // ----------------------------------------------------------------
   // clock and link rates
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ   = 100_000_000;
   localparam int unsigned I2C_HZ   = 400_000;
   localparam int unsigned SPI_HZ   = 4_000_000;
   localparam int unsigned LIN_BAUD = 20_000;
   // host bit = four quarters; least times round up
   localparam int unsigned I2C_QCYC = (CLK_HZ + 4 * I2C_HZ - 1) / (4 * I2C_HZ);
   localparam int unsigned SPI_QCYC = (CLK_HZ + 4 * SPI_HZ - 1) / (4 * SPI_HZ);
   localparam int unsigned LIN_BIT  = CLK_HZ / LIN_BAUD;
   localparam int unsigned LIN_QCYC = LIN_BIT / 4;
   // ----------------------------------------------------------------
   // straps, addresses, frame lengths
   // ----------------------------------------------------------------
   localparam logic [6:0] I2C_ADDR_LO = 7'h66;
   localparam logic [6:0] I2C_ADDR_HI = 7'h67;
   localparam logic [3:0] STRAP_WAIT  = 4'h8;
   localparam logic [4:0] I2C_BITS    = 5'h14;
   localparam logic [4:0] SPI_BITS    = 5'h08;
   localparam logic [4:0] LIN_BITS    = 5'h0a;
   // synchroniser bit positions on the device side
   localparam int unsigned PIN_P0   = 0;
   localparam int unsigned PIN_P1   = 1;
   localparam int unsigned PIN_ADDR = 2;
   localparam int unsigned PIN_BUS  = 3;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {HIMS_NONE, HIMS_I2C, HIMS_SPI, HIMS_LIN} hims_mode_t;
   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK, I_WR, I_RD, I_RACK} hims_i2c_st_t;
endpackage

/* hims_if.sv */
// link pins between the touch device and its host, resolved as pulled-up wires
`timescale 1ns/1ps
interface hims_if;
   // device drives
   logic d_p0_o, d_p0_oe_n, d_p1_o, d_p1_oe_n, d_irq_o, d_irq_oe_n, d_bus_o, d_bus_oe_n;
   // host drives
   logic h_p0_o, h_p0_oe_n, h_p1_o, h_p1_oe_n, h_addr_o, h_addr_oe_n, h_bus_o, h_bus_oe_n;
   // wire levels: a released pin floats high, a low driver wins
   logic p0, p1, irq, addr, bus;
   assign p0   = (d_p0_oe_n | d_p0_o) & (h_p0_oe_n | h_p0_o);
   assign p1   = (d_p1_oe_n | d_p1_o) & (h_p1_oe_n | h_p1_o);
   assign irq  = d_irq_oe_n | d_irq_o;
   assign addr = h_addr_oe_n | h_addr_o;
   assign bus  = (d_bus_oe_n | d_bus_o) & (h_bus_oe_n | h_bus_o);
   modport dev (output d_p0_o, d_p0_oe_n, d_p1_o, d_p1_oe_n, d_irq_o, d_irq_oe_n,
                d_bus_o, d_bus_oe_n, input p0, p1, addr, bus);
   modport host (output h_p0_o, h_p0_oe_n, h_p1_o, h_p1_oe_n, h_addr_o, h_addr_oe_n,
                 h_bus_o, h_bus_oe_n, input p0, p1, irq, bus);
endinterface // hims_if

/* hims_host.sv */
// host end: strap drive and one-transfer master for i2c, spi or lin
`timescale 1ns/1ps
module hims_host import hims_pkg::*; #(
   parameter int unsigned LIN_QCYC_P = LIN_QCYC
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // link pins
   hims_if.host            lnk,
   // board straps and requests
   input  wire logic       cfg_bus,
   input  wire logic       cfg_addr,
   input  wire logic       go,
   input  wire logic       rd,
   input  wire logic [6:0] dev_addr,
   input  wire logic [7:0] wr_byte,
   // answers
   output logic            busy_q,
   output logic            done_q,
   output logic [7:0]      rd_data_q,
   output logic            nack_q,
   output logic            irq_q
);
   // ----------------------------------------------------------------
   // synchronisers and quarter-bit sequencer
   // ----------------------------------------------------------------
   logic [2:0]  s1_q, s2_q, s3_q, f_q, f_d;
   logic [4:0]  bit_q, bit_d, nb;
   logic [1:0]  qtr_q, qtr_d;
   logic [11:0] tick_q, tick_d, qc;
   logic [7:0]  ab_q, ab_d, db_q, db_d, sh_q, sh_d;
   logic        rd_q, rd_d, nack_d, done_d, busy_d, bv, qend, sv;
   logic        p0_v, p1_v, p0_oe_n_q, p1_o_q, p1_oe_n_q, p0_o_q, m_o_q;
   logic        spi_m, i2c_m;

   assign f_d   = (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
   assign i2c_m = ~cfg_bus;
   assign spi_m = cfg_bus & cfg_addr;
   assign qc    = i2c_m ? 12'(I2C_QCYC) : spi_m ? 12'(SPI_QCYC) : 12'(LIN_QCYC_P);
   assign nb    = i2c_m ? I2C_BITS : spi_m ? SPI_BITS : LIN_BITS;
   assign qend  = busy_q && tick_q == qc - 12'h001;
   assign sv    = i2c_m ? f_q[0] : f_q[1];

   // value of the current bit for each framing
   always_comb begin
      bv = 1'b1;
      if (i2c_m) begin
         if (bit_q >= 5'h01 && bit_q <= 5'h08)
            bv = ab_q[3'(5'h08 - bit_q)];
         else if (bit_q >= 5'h0a && bit_q <= 5'h11)
            bv = rd_q | db_q[3'(5'h11 - bit_q)];
      end else if (spi_m) begin
         bv = db_q[~bit_q[2:0]];
      end else if (bit_q == 5'h00) begin
         bv = 1'b0;
      end else if (bit_q <= 5'h08) begin
         bv = db_q[3'(bit_q - 5'h01)];
      end
   end

   // pin levels per quarter; mode 0 clock idles low and rises mid-bit
   always_comb begin
      p0_v = 1'b1;
      p1_v = 1'b1;
      if (i2c_m) begin
         if (busy_q && bit_q == 5'h00) begin
            p0_v = (qtr_q == 2'h0);
            p1_v = ~qtr_q[1];
         end else if (busy_q && bit_q == I2C_BITS - 5'h01) begin
            p0_v = qtr_q[1];
            p1_v = (qtr_q != 2'h0);
         end else if (busy_q) begin
            p0_v = bv;
            p1_v = qtr_q[0] ^ qtr_q[1];
         end
      end else if (spi_m) begin
         p0_v = busy_q & qtr_q[1];
         p1_v = ~busy_q;
      end else begin
         p0_v = ~busy_q | bv;
      end
   end

   always_comb begin
      busy_d = busy_q;
      bit_d  = bit_q;
      qtr_d  = qtr_q;
      tick_d = tick_q;
      ab_d   = ab_q;
      db_d   = db_q;
      sh_d   = sh_q;
      rd_d   = rd_q;
      nack_d = nack_q;
      done_d = 1'b0;
      if (!busy_q) begin
         if (go) begin
            busy_d = 1'b1;
            bit_d  = 5'h00;
            qtr_d  = 2'h0;
            tick_d = 12'h000;
            ab_d   = {dev_addr, rd};
            db_d   = wr_byte;
            rd_d   = rd;
            nack_d = 1'b0;
         end
      end else begin
         tick_d = tick_q + 12'h001;
         if (qend) begin
            tick_d = 12'h000;
            qtr_d  = qtr_q + 2'h1;
            // sample at the end of quarter 1: just before the spi clock rises, mid clock-high in i2c
            if (qtr_q == 2'h1) begin
               if (spi_m || (i2c_m && rd_q && bit_q >= 5'h0a && bit_q <= 5'h11))
                  sh_d = {sh_q[6:0], sv};
               if (i2c_m && (bit_q == 5'h09 || (bit_q == 5'h12 && !rd_q)))
                  nack_d = nack_q | sv;
            end
            if (qtr_q == 2'h3) begin
               bit_d = bit_q + 5'h01;
               if (bit_q == nb - 5'h01) begin
                  busy_d = 1'b0;
                  done_d = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s1_q      <= 3'h7;
         s2_q      <= 3'h7;
         s3_q      <= 3'h7;
         f_q       <= 3'h7;
         busy_q    <= 1'b0;
         bit_q     <= 5'h00;
         qtr_q     <= 2'h0;
         tick_q    <= 12'h000;
         ab_q      <= 8'h00;
         db_q      <= 8'h00;
         sh_q      <= 8'h00;
         rd_q      <= 1'b0;
         nack_q    <= 1'b0;
         done_q    <= 1'b0;
         rd_data_q <= 8'h00;
         irq_q     <= 1'b0;
         p0_o_q    <= 1'b1;
         p0_oe_n_q <= 1'b1;
         p1_o_q    <= 1'b1;
         p1_oe_n_q <= 1'b1;
         m_o_q     <= 1'b1;
      end else begin
         s1_q      <= {lnk.irq, lnk.bus, lnk.p0};
         s2_q      <= s1_q;
         s3_q      <= s2_q;
         f_q       <= f_d;
         busy_q    <= busy_d;
         bit_q     <= bit_d;
         qtr_q     <= qtr_d;
         tick_q    <= tick_d;
         ab_q      <= ab_d;
         db_q      <= db_d;
         sh_q      <= sh_d;
         rd_q      <= rd_d;
         nack_q    <= nack_d;
         done_q    <= done_d;
         irq_q     <= ~f_q[2];
         if (done_d)
            rd_data_q <= sh_d;
         // open drain in i2c, push-pull otherwise; lin leaves p1 to the device
         p0_o_q    <= p0_v & ~i2c_m;
         p0_oe_n_q <= i2c_m & p0_v;
         p1_o_q    <= p1_v & ~i2c_m;
         p1_oe_n_q <= i2c_m ? p1_v : ~spi_m;
         // address strap stays driven; in spi it carries host data out
         m_o_q     <= (spi_m & busy_q) ? bv : cfg_addr;
      end
   end

   // bus strap: tied low for i2c, left to the pull-up otherwise
   assign lnk.h_p0_o      = p0_o_q;
   assign lnk.h_p0_oe_n   = p0_oe_n_q;
   assign lnk.h_p1_o      = p1_o_q;
   assign lnk.h_p1_oe_n   = p1_oe_n_q;
   // strap level from the board choice, except in spi where it carries host data out while busy
   assign lnk.h_addr_o    = spi_m ? m_o_q : cfg_addr;
   assign lnk.h_addr_oe_n = 1'b0;
   assign lnk.h_bus_o     = 1'b0;
   assign lnk.h_bus_oe_n  = cfg_bus;
endmodule // hims_host

/* hims_checker.sv */
// link pin assertions for the mode select block
`timescale 1ns/1ps
module hims_checker (
   // clock, reset
   input wire logic ref_clk,
   input wire logic nrst,
   // pins
   input wire logic d_p0_o,
   input wire logic d_p0_oe_n,
   input wire logic d_p1_oe_n,
   input wire logic d_irq_oe_n,
   input wire logic d_bus_o,
   input wire logic d_bus_oe_n,
   input wire logic h_bus_oe_n,
   input wire logic p0,
   input wire logic p1,
   input wire logic addr
);
   logic [3:0] cnt_q, cnt_d;
   logic       spi_q, spi_d;
   // age since reset; spi_q marks that spi traffic has begun
   always_comb begin
      cnt_d = cnt_q + {3'h0, cnt_q != 4'hf};
      spi_d = spi_q | !d_bus_oe_n;
   end
   // registers only
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 4'h0;
         spi_q <= 1'h0;
      end else begin
         cnt_q <= cnt_d;
         spi_q <= spi_d;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // first pin held high over two samples
   sequence s_hi; p0 && $past(p0); endsequence
   property p_quiet; cnt_q < 4'h8 |-> d_p0_oe_n && d_p1_oe_n && d_bus_oe_n && d_irq_oe_n; endproperty
   a_quiet: assert property (p_quiet) else $error("pin driven early");
   property p_sda_od; !d_p0_oe_n |-> !d_p0_o && d_p1_oe_n; endproperty
   a_sda_od: assert property (p_sda_od) else $error("data pin high or clock pin taken");
   property p_sda_hold; p1 && $past(p1) |-> $stable(d_p0_oe_n); endproperty
   a_sda_hold: assert property (p_sda_hold) else $error("data moved in clock high");
   property p_miso_hold; s_hi ##0 !d_bus_oe_n |-> $stable(d_bus_o); endproperty
   a_miso_hold: assert property (p_miso_hold) else $error("miso moved in sck high");
   property p_miso_off; spi_q && $rose(p1) |-> ##[1:8] d_bus_oe_n; endproperty
   a_miso_off: assert property (p_miso_off) else $error("miso kept after select");
   property p_sck_idle; spi_q && p1 |-> !p0; endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("sck not idle low");
   property p_mosi_hold; s_hi |-> $stable(addr); endproperty
   a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved in sck high");
   property p_strap; $stable(h_bus_oe_n); endproperty
   a_strap: assert property (p_strap) else $error("strap moved");
endmodule // hims_checker

/* testbench.sv */
// bench joining device and host ends over the link
`timescale 1ns/1ps
module testbench import hims_pkg::*;;
   logic ref_clk = 1'h0, nrst = 1'h0, rpt_evt = 1'h0, tx_go = 1'h0, lin_en = 1'h0;
   logic cfg_bus = 1'h0, cfg_addr = 1'h0, go = 1'h0, rd = 1'h0;
   logic [7:0] tx_data = 8'h00, wr_byte = 8'h00, rx_data_q, rd_data_q, a, b;
   logic [6:0] dev_addr = 7'h00, i2c_addr_q, ad;
   logic [9:0] w;
   logic rx_valid_q, tx_take_q, rpt_pend_q, busy_q, done_q, nack_q, irq_q;
   hims_mode_t mode_q;
   int err_count = 0, num_checks = 0, m, s, nrx = 0, ntk = 0;
   hims_if lnk ();
   hims_dev #(.LIN_BIT_CYC(40)) u_hims_dev (.lnk(lnk.dev), .*);
   hims_host #(.LIN_QCYC_P(10)) u_hims_host (.lnk(lnk.host), .*);
   hims_checker u_hims_checker (.ref_clk(ref_clk), .nrst(nrst), .d_p0_o(lnk.d_p0_o),
      .d_p0_oe_n(lnk.d_p0_oe_n), .d_p1_oe_n(lnk.d_p1_oe_n), .d_irq_oe_n(lnk.d_irq_oe_n),
      .d_bus_o(lnk.d_bus_o), .d_bus_oe_n(lnk.d_bus_oe_n), .h_bus_oe_n(lnk.h_bus_oe_n),
      .p0(lnk.p0), .p1(lnk.p1), .addr(lnk.addr));
   // 100 mhz clock
   always #5 ref_clk = ~ref_clk;
   // pulse counts; each accepted or offered byte gives exactly one
   always @(negedge ref_clk) begin
      nrx += rx_valid_q;
      ntk += tx_take_q;
   end
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // one host transfer, waited out under a bound
   task automatic xfer(input logic r, input logic [6:0] da, input logic [7:0] wb);
      rd = r;
      dev_addr = da;
      wr_byte = wb;
      go = 1'h1;
      @(negedge ref_clk) go = 1'h0;
      chk("busy", busy_q, 1'h1);
      for (s = 0; s < 9000 && done_q !== 1'h1; s++) @(negedge ref_clk);
      chk("done", done_q, 1'h1);
   endtask
   // watchdog: whole run is about 32k cycles
   initial begin
      repeat (60000) @(posedge ref_clk);
      err_count++;
      $display("MISMATCH watchdog expected done seen hang");
      finish_test();
   end
   // straps i2c low, i2c high, spi, lin; each after its own reset
   initial begin
      void'($urandom(32'h064e8a36));
      for (m = 0; m < 4; m++) begin
         @(negedge ref_clk) nrst = 1'h0;
         cfg_bus = m[1];
         cfg_addr = m[0] ^ m[1];
         repeat (16) @(negedge ref_clk);
         nrst = 1'h1;
         repeat (30) @(negedge ref_clk);
         chk("mode", mode_q, !cfg_bus ? HIMS_I2C : cfg_addr ? HIMS_SPI : HIMS_LIN);
         a = $urandom;
         b = $urandom;
         tx_data = a;
         lin_en = $urandom;
         ad = {6'h33, cfg_addr};
         rpt_evt = 1'h1;
         @(negedge ref_clk) rpt_evt = 1'h0;
         repeat (6) @(negedge ref_clk);
         chk("irq", irq_q, (cfg_bus && !cfg_addr) ? !lin_en : 1'h1);
         if (!cfg_bus) begin
            chk("addr", i2c_addr_q, ad);
            xfer(1'h0, ad, b);
            chk("wr", {nack_q, rx_data_q}, {1'h0, b});
            xfer(1'h1, ad, 8'h00);
            chk("rd", {irq_q, rpt_pend_q, rd_data_q}, {2'h0, a});
            xfer(1'h0, ad ^ 7'h01, b);
            chk("nack", nack_q, 1'h1);
         end else if (cfg_addr) begin
            xfer(1'h0, 7'h00, b);
            chk("spi", {rd_data_q, rx_data_q}, {a, b});
            chk("spi_pend", rpt_pend_q, 1'h0);
         end else begin
            xfer(1'h0, 7'h00, b);
            chk("lin_rx", rx_data_q, b);
            tx_go = 1'h1;
            @(negedge ref_clk) tx_go = 1'h0;
            for (s = 0; s < 60 && lnk.p1; s++) @(negedge ref_clk);
            repeat (20) @(negedge ref_clk);
            for (s = 0; s < 10; s++) begin
               w = {lnk.p1, w[9:1]};
               repeat (40) @(negedge ref_clk);
            end
            chk("lin_tx", w, {1'h1, a, 1'h0});
         end
         chk("pulses", {8'(nrx), 8'(ntk)}, {2{8'(m + 1)}});
         $display("strap test %0d done", m);
      end
      finish_test();
   end
endmodule // testbench
